/* sbt_jtag_ctl.sv */
// Behavioural boundary-scan controller that drives the test port
`timescale 1ns/10ps
module sbt_jtag_ctl
(
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    input wire logic tdo_in,
    input wire logic tdo_oe_in
);
    int oe_bad = 0;
    initial
    begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // ------------------------------------------------------------
    // One test-clock period; the clock stands low between frames
    // ------------------------------------------------------------
    task automatic step(input logic m, input logic d, input logic sh,
                        output logic q);
        tms_out = m;
        tdi_out = sh ? d : ~tdi_out; // Unused data line toggles
        #3 tck_out = 1'b1;
        q = tdo_in;
        if (tdo_oe_in !== sh)
            oe_bad++;
        #3 tck_out = 1'b0;
    endtask
    // Mode-select pattern, first bit in bit 0
    task automatic walk(input logic [7:0] seq, input int n);
        logic q;
        for (int i = 0; i < n; i++)
            step(seq[i], 1'b0, 1'b0, q);
    endtask
    // From Idle: shift n bits through IR or DR, LSB first, back to Idle
    // Only documented instruction codes are ever passed
    task automatic scan(input logic ir, input int n,
                        input logic [108:0] din, output logic [108:0] dout);
        logic q;
        dout = '0;
        walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], 1'b1, q);
            dout[i] = q;
        end
        walk(8'h01, 2);
    endtask
endmodule

/* sbt_pkg.sv */
// Package: constants and types of the SRAM boundary-scan test port
package sbt_pkg;

    // ----------------------------------------------------------------
    // Register sizes
    // ----------------------------------------------------------------
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_W = 109;
    localparam int RING_W = 108;
    localparam int OE_CELL = 108;

    // ----------------------------------------------------------------
    // Instruction codes
    // ----------------------------------------------------------------
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDCODE = 3'h1;
    localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [2:0] INS_PRELOAD = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;
    localparam logic [1:0] IR_CAPTURE = 2'h1;
    localparam logic IR_CAP_MSB = 1'h0;

    // ----------------------------------------------------------------
    // Identification fields (values are arbitrary)
    // ----------------------------------------------------------------
    localparam logic [2:0] ID_REVISION = 3'h5;
    localparam logic [16:0] ID_DEVICE = 17'h0_1234;
    localparam logic [10:0] ID_VENDOR = 11'h0_2a5;
    localparam logic ID_PRESENT = 1'h1;
    localparam logic [31:0] ID_VALUE =
        {ID_REVISION, ID_DEVICE, ID_VENDOR, ID_PRESENT};

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic OE_CELL_RESET = 1'h1;
    localparam logic BYPASS_CAPTURE = 1'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
        ST_PAUSE_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SH_IR, ST_EX1_IR, ST_PAUSE_IR, ST_EX2_IR, ST_UPD_IR
    } sbt_state_e;

    typedef struct packed {
        logic tms;
        logic tdi;
    } sbt_link_s;

endpackage

/* sbt_tap.sv */
// Boundary-scan test access port of the SRAM, on the test clock except the output enable, which leaves on the memory clock
`timescale 1ns/10ps
module sbt_tap
    import sbt_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    input wire logic [RING_W-1:0] ring_in,
    output logic tdo_out,
    output logic tdo_oe_out,
    output logic [RING_W-1:0] ring_drive_out,
    output logic extest_out,
    output logic q_drive_en_out
);

    // ----------------------------------------------------------------
    // Controller state
    // ----------------------------------------------------------------
    sbt_link_s link;
    sbt_state_e state, next_state;
    assign link = '{tms: tms_in, tdi: tdi_in};

    always_comb
    begin
        unique case (state)
            ST_RESET: next_state = link.tms ? ST_RESET : ST_IDLE;
            ST_IDLE: next_state = link.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = link.tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = link.tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: next_state = link.tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = link.tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = link.tms ? ST_EX2_DR : ST_PAUSE_DR;
            ST_EX2_DR: next_state = link.tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: next_state = link.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = link.tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_state = link.tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: next_state = link.tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = link.tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = link.tms ? ST_EX2_IR : ST_PAUSE_IR;
            ST_EX2_IR: next_state = link.tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: next_state = link.tms ? ST_SEL_DR : ST_IDLE;
        endcase
    end

    always_ff @(posedge tck_in or posedge rst_in)
    begin
        if (rst_in)
            state <= ST_RESET;
        else
            state <= next_state;
    end

    // ----------------------------------------------------------------
    // Ring synchroniser
    // ----------------------------------------------------------------
    // Pins move on the memory clock, so they settle before the chain
    logic [RING_W-1:0] ring_s1, ring_s2;

    always_ff @(posedge tck_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ring_s1 <= '0;
            ring_s2 <= '0;
        end
        else
        begin
            ring_s1 <= ring_in;
            ring_s2 <= ring_s1;
        end
    end

    // ----------------------------------------------------------------
    // Instruction and data registers
    // ----------------------------------------------------------------
    logic [IR_W-1:0] ir_sh, ir, next_ir_sh, next_ir;
    logic byp, next_byp;
    logic [ID_W-1:0] id_sh, next_id_sh;
    logic [BSR_W-1:0] bsr_sh, bsr_upd, next_bsr_sh, next_bsr_upd;
    logic sel_bsr, sel_id;
    assign sel_bsr = (ir == INS_EXTEST) || (ir == INS_SAMPLE_Z)
        || (ir == INS_PRELOAD);
    assign sel_id = (ir == INS_IDCODE);
    always_comb
    begin
        next_ir_sh = ir_sh;
        next_ir = ir;
        next_byp = byp;
        next_id_sh = id_sh;
        next_bsr_sh = bsr_sh;
        next_bsr_upd = bsr_upd;
        unique case (state)
            ST_RESET:
            begin
                next_ir = INS_IDCODE;
                next_bsr_upd[OE_CELL] = OE_CELL_RESET;
            end
            ST_CAP_IR: next_ir_sh = {IR_CAP_MSB, IR_CAPTURE};
            ST_SH_IR: next_ir_sh = {link.tdi, ir_sh[IR_W-1:1]};
            ST_UPD_IR: next_ir = ir_sh;
            ST_CAP_DR:
            begin
                if (sel_id)
                    next_id_sh = ID_VALUE;
                else if (sel_bsr)
                    next_bsr_sh = {bsr_upd[OE_CELL], ring_s2};
                else
                    next_byp = BYPASS_CAPTURE;
            end
            ST_SH_DR:
            begin
                if (sel_id)
                    next_id_sh = {link.tdi, id_sh[ID_W-1:1]};
                else if (sel_bsr)
                    next_bsr_sh = {link.tdi, bsr_sh[BSR_W-1:1]};
                else
                    next_byp = link.tdi;
            end
            ST_UPD_DR:
                if (sel_bsr)
                    next_bsr_upd = bsr_sh;
            default: next_ir = ir;
        endcase
    end

    always_ff @(posedge tck_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ir_sh <= INS_IDCODE;
            ir <= INS_IDCODE;
            byp <= BYPASS_CAPTURE;
            id_sh <= ID_VALUE;
            bsr_sh <= '0;
            bsr_upd <= {OE_CELL_RESET, {RING_W{1'b0}}};
        end
        else
        begin
            ir_sh <= next_ir_sh;
            ir <= next_ir;
            byp <= next_byp;
            id_sh <= next_id_sh;
            bsr_sh <= next_bsr_sh;
            bsr_upd <= next_bsr_upd;
        end
    end

    // ----------------------------------------------------------------
    // Output-driver control
    // ----------------------------------------------------------------
    // Reserved codes fall through to the bypass path and leave outputs on
    // Fed from next values: the test clock may stop right after an update
    logic q_en_tck, next_q_en_tck, next_extest;
    always_comb
    begin
        next_extest = (next_ir == INS_EXTEST);
        if (next_ir == INS_SAMPLE_Z)
            next_q_en_tck = 1'h0;
        else if (next_ir == INS_EXTEST)
            next_q_en_tck = next_bsr_upd[OE_CELL];
        else
            next_q_en_tck = 1'h1;
    end

    always_ff @(posedge tck_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            q_en_tck <= 1'b1;
            extest_out <= 1'b0;
            ring_drive_out <= '0;
        end
        else
        begin
            q_en_tck <= next_q_en_tck;
            extest_out <= next_extest;
            ring_drive_out <= next_bsr_upd[RING_W-1:0];
        end
    end

    // Level crossing into the memory clock
    logic q_en_s1;
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            q_en_s1 <= 1'b1;
            q_drive_en_out <= 1'b1;
        end
        else
        begin
            q_en_s1 <= q_en_tck;
            q_drive_en_out <= q_en_s1;
        end
    end

    // ----------------------------------------------------------------
    // Serial output on the falling edge
    // ----------------------------------------------------------------
    logic next_tdo, next_tdo_oe;
    always_comb
    begin
        next_tdo_oe = (state == ST_SH_IR) || (state == ST_SH_DR);
        if (state == ST_SH_IR)
            next_tdo = ir_sh[0];
        else if (sel_id)
            next_tdo = id_sh[0];
        else if (sel_bsr)
            next_tdo = bsr_sh[0];
        else
            next_tdo = byp;
    end

    always_ff @(negedge tck_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            tdo_out <= 1'b0;
            tdo_oe_out <= 1'b0;
        end
        else
        begin
            tdo_out <= next_tdo;
            tdo_oe_out <= next_tdo_oe;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_tms_high5;
        tms_in [*5];
    endsequence
    chk_reset_walk: assert property (
        @(posedge tck_in) disable iff (rst_in)
        s_tms_high5 |=> state == ST_RESET)
        else $error("five high mode-select edges did not reach reset");
    chk_id_capture: assert property (
        @(posedge tck_in) disable iff (rst_in)
        (state == ST_CAP_DR) && sel_id |=> id_sh == ID_VALUE
            && id_sh[0] == 1'h1)
        else $error("identification word capture wrong");
    chk_capir_pattern: assert property (
        @(posedge tck_in) disable iff (rst_in)
        state == ST_CAP_IR |=> ir_sh[1:0] == 2'h1)
        else $error("capture-ir pattern wrong");
    chk_reset_idcode: assert property (
        @(posedge tck_in) disable iff (rst_in)
        state == ST_RESET |=> ir == INS_IDCODE)
        else $error("reset state did not load identification code");
    chk_samplez_hiz: assert property (
        @(posedge tck_in) disable iff (rst_in)
        ir == INS_SAMPLE_Z |-> !q_en_tck)
        else $error("outputs not forced off under sample-z");
    chk_bypass_zero: assert property (
        @(posedge tck_in) disable iff (rst_in)
        (ir == INS_BYPASS) && (state == ST_CAP_DR) |=> !byp)
        else $error("bypass stage not cleared on capture");
    chk_extest_gate: assert property (
        @(posedge tck_in) disable iff (rst_in)
        ir == INS_EXTEST |-> q_en_tck == bsr_upd[OE_CELL])
        else $error("cell 108 did not gate outputs in external test");
    chk_ring_capture: assert property (
        @(posedge tck_in) disable iff (rst_in)
        (ir == INS_PRELOAD) && (state == ST_CAP_DR)
            |=> bsr_sh[RING_W-1:0] == $past(ring_s2))
        else $error("ring capture into the chain wrong");
    chk_update_ir: assert property (
        @(posedge tck_in) disable iff (rst_in)
        state == ST_UPD_IR |=> ir == $past(ir_sh))
        else $error("update-ir did not make the code current");
    chk_tdo_fall: assert property (
        @(negedge tck_in) disable iff (rst_in)
        state == ST_SH_IR |=> tdo_out == $past(ir_sh[0]))
        else $error("serial output not moved on the falling edge");

endmodule

/* sram_boundary_scan_tap_test.sv */
// Self-checking bench of the SRAM boundary-scan test port
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("FAIL %s exp %h got %h", nm, e, g); end end
module sram_boundary_scan_tap_test;
    import sbt_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_in = 1'h0;
    logic [RING_W-1:0] ring_in = '0;
    logic tck, tms, tdi, tdo, tdo_oe, extest, q_en;
    logic [RING_W-1:0] ring_drive;
    logic [108:0] got;
    int n_fail = 0;
    int checked = 0;
    localparam logic [107:0] RA = {27{4'h5}};
    localparam logic [107:0] RB = {27{4'hc}};
    localparam logic [107:0] PA = {27{4'h3}};
    localparam logic [107:0] PB = {27{4'h9}};
    always #50 mclk_in = ~mclk_in;
    sbt_jtag_ctl ctl (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
        .tdo_in(tdo), .tdo_oe_in(tdo_oe));
    sbt_tap DUT (.mclk_in(mclk_in), .rst_in(rst_in), .tck_in(tck),
        .tms_in(tms), .tdi_in(tdi), .ring_in(ring_in), .tdo_out(tdo),
        .tdo_oe_out(tdo_oe), .ring_drive_out(ring_drive),
        .extest_out(extest), .q_drive_en_out(q_en));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic ir(input logic [2:0] c);
        ctl.scan(1'b1, 3, {106'h0, c}, got);
    endtask
    task automatic dr(input int n, input logic [108:0] d);
        ctl.scan(1'b0, n, d, got);
    endtask
    // Enable crosses to the memory clock within 3 mclk edges
    task automatic settle();
        repeat (4) @(posedge mclk_in);
        #1;
    endtask
    task automatic put_ring(input logic [107:0] v);
        @(posedge mclk_in);
        #1 ring_in = v;
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_id();
        ctl.walk(8'h00, 1);
        dr(32, '0);
        `CHK("idcode", ID_VALUE, got[31:0])
        `CHK("id_bit0", 1'h1, got[0])
        `CHK("q_en_id", 1'h1, q_en)
    endtask
    task automatic t_bypass();
        ir(INS_BYPASS);
        `CHK("ir_capture", 3'h1, got[2:0])
        dr(8, {101'h0, 8'ha5});
        `CHK("bypass", 8'h4a, got[7:0])
        settle();
        `CHK("q_en_byp", 1'h1, q_en)
    endtask
    task automatic t_sample_z();
        put_ring(RA);
        ir(INS_SAMPLE_Z);
        settle();
        `CHK("q_en_z", 1'h0, q_en)
        dr(109, '0);
        `CHK("ring_z", RA, got[107:0])
        `CHK("cell108_rst", 1'h1, got[108])
    endtask
    task automatic t_preload();
        put_ring(RB);
        ir(INS_PRELOAD);
        settle();
        `CHK("q_en_pre", 1'h1, q_en)
        dr(109, {1'b0, PA});
        `CHK("ring_pre", RB, got[107:0])
        `CHK("drive_pre", PA, ring_drive)
        `CHK("ext_pre", 1'h0, extest)
    endtask
    task automatic t_extest();
        ir(INS_EXTEST);
        settle();
        `CHK("ext_on", 1'h1, extest)
        `CHK("q_en_cell0", 1'h0, q_en)
        dr(109, {1'b1, PB});
        `CHK("ring_ext", RB, got[107:0])
        `CHK("drive_ext", PB, ring_drive)
        settle();
        `CHK("q_en_cell1", 1'h1, q_en)
        dr(109, {1'b0, PB});
        settle();
        `CHK("q_en_cell0b", 1'h0, q_en)
    endtask
    task automatic t_tap_reset();
        ctl.walk(8'h1f, 6);
        ctl.walk(8'h00, 1);
        `CHK("ext_off", 1'h0, extest)
        dr(32, '0);
        `CHK("id_again", ID_VALUE, got[31:0])
        ir(INS_EXTEST);
        settle();
        `CHK("q_en_preset", 1'h1, q_en)
    endtask
    initial
    begin
        rst_in = 1'h1;
        ctl.walk(8'h1f, 2);
        repeat (2) @(posedge mclk_in);
        #1 rst_in = 1'b0;
        t_reset_id();
        t_bypass();
        t_sample_z();
        t_preload();
        t_extest();
        t_tap_reset();
        `CHK("oe_in_shift", 0, ctl.oe_bad)
        report_and_stop();
    end
    // Whole run needs well under 20 us
    initial
    begin
        #100_000;
        n_fail++;
        report_and_stop();
    end
endmodule
